// ===== rtl/plc_link_ctrl.sv
// link control registers, fast link-down logic and extended register access
// assumes a management frame engine on ref_clk_i issuing one-cycle word accesses
// and a same-clock extended register file answering ext reads within one cycle
`timescale 1ns/1ps
module plc_link_ctrl
    import plc_pkg::*;
(
    input  wire logic           ref_clk_i,
    input  wire logic           rst_i,
    input  wire plc_mgmt_req_s  mgmt_req_i,
    output logic [15:0]         mgmt_rdata_o,
    output logic                mgmt_rvalid_o,
    output logic                ext_wr_o,
    output logic                ext_rd_o,
    output logic [15:0]         ext_addr_o,
    output logic [15:0]         ext_wdata_o,
    input  wire logic [15:0]    ext_rdata_i,
    input  wire logic           rx_sym_err_i,
    input  wire logic           rx_idle_i,
    output logic                idle_sym_err_o,
    input  wire logic           tx_nib_stb_i,
    input  wire logic           tx_en_i,
    input  wire logic           tx_er_i,
    output logic                tx_en_o,
    output logic                tx_er_o,
    output logic                rmii_ref_rx_clk_o,
    output logic                pair_polarity_inv_o,
    output logic                pair_swap_o,
    output logic                port_mirror_o,
    input  wire plc_fault_evt_s fault_evt_i,
    output logic                link_drop_o
);
    logic [15:0] cr2_r;
    logic [15:0] lfp_r;
    logic [15:0] iac_r;
    logic [15:0] ptr_r;
    logic [15:0] rd_word;
    logic        rd_pend_r;
    logic        rd_ext_r;
    logic [15:0] rd_hold_r;
    logic        dev_ok;
    logic        win_acc;
    logic        ptr_inc;
    plc_func_e   func;
    logic [10:0] win_cnt_r;
    logic        win_start;
    logic        rx_err_hit;
    logic        tern_hit;
    logic        snr_hit;
    logic        nib_odd_r;
    logic        stretch_r;

    function automatic logic hit_addr(input plc_mgmt_req_s req, input logic [4:0] a);
        hit_addr = (req.addr == a);
    endfunction

    assign func    = plc_func_e'(iac_r[IAC_FUNC_HI:IAC_FUNC_LO]);
    assign dev_ok  = (iac_r[4:0] == TARGET_DEVICE_CODE);
    assign win_acc = hit_addr(mgmt_req_i, ADDR_INDIRECT_WINDOW) && dev_ok
                     && func != PLC_FN_ADDR;

    // register writes
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cr2_r <= RST_RX_ERR_RMII_CTRL;
            lfp_r <= RST_LINK_FAULT_PAIR;
            iac_r <= RST_INDIRECT_CTRL;
        end else if (mgmt_req_i.wr) begin
            if (hit_addr(mgmt_req_i, ADDR_RX_ERR_RMII_CTRL)) begin
                cr2_r <= mgmt_req_i.wdata;
            end
            if (hit_addr(mgmt_req_i, ADDR_LINK_FAULT_PAIR)) begin
                lfp_r <= mgmt_req_i.wdata & LFP_WRITABLE_MASK;
            end
            if (hit_addr(mgmt_req_i, ADDR_INDIRECT_CTRL)) begin
                iac_r <= mgmt_req_i.wdata & IAC_WRITABLE_MASK;
            end
        end
    end

    // pointer increments only after the access it served
    always_comb begin
        ptr_inc = 1'b0;
        if (win_acc) begin
            unique case (func)
                PLC_FN_ADDR:        ptr_inc = 1'b0;
                PLC_FN_DATA:        ptr_inc = 1'b0;
                PLC_FN_DATA_INC_RW: ptr_inc = mgmt_req_i.wr || mgmt_req_i.rd;
                PLC_FN_DATA_INC_WR: ptr_inc = mgmt_req_i.wr;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ptr_r <= RST_EXT_POINTER;
        end else if (mgmt_req_i.wr && hit_addr(mgmt_req_i, ADDR_INDIRECT_WINDOW)
                     && dev_ok && func == PLC_FN_ADDR) begin
            ptr_r <= mgmt_req_i.wdata;
        end else if (ptr_inc) begin
            ptr_r <= ptr_r + 16'h0001;
        end
    end

    // extended register strobes carry the pointer as it was before the increment
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ext_wr_o    <= 1'b0;
            ext_rd_o    <= 1'b0;
            ext_addr_o  <= 16'h0000;
            ext_wdata_o <= 16'h0000;
        end else begin
            ext_wr_o <= win_acc && mgmt_req_i.wr;
            ext_rd_o <= win_acc && mgmt_req_i.rd && !mgmt_req_i.wr;
            if (win_acc) begin
                ext_addr_o  <= ptr_r;
                ext_wdata_o <= mgmt_req_i.wdata;
            end
        end
    end

    // local read mux; window in address mode returns the pointer
    always_comb begin
        rd_word = 16'h0000;
        unique case (mgmt_req_i.addr)
            ADDR_RX_ERR_RMII_CTRL: rd_word = cr2_r;
            ADDR_LINK_FAULT_PAIR:  rd_word = lfp_r & LFP_WRITABLE_MASK;
            ADDR_INDIRECT_CTRL:    rd_word = iac_r;
            ADDR_INDIRECT_WINDOW:  rd_word = (dev_ok && func == PLC_FN_ADDR) ? ptr_r : 16'h0000;
            default:               rd_word = 16'h0000;
        endcase
    end

    // every read answers two cycles after it is taken, so extended reads line up
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_pend_r <= 1'b0;
            rd_ext_r  <= 1'b0;
            rd_hold_r <= 16'h0000;
        end else begin
            rd_pend_r <= mgmt_req_i.rd && !mgmt_req_i.wr;
            rd_ext_r  <= win_acc;
            rd_hold_r <= rd_word;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mgmt_rvalid_o <= 1'b0;
            mgmt_rdata_o  <= 16'h0000;
        end else begin
            mgmt_rvalid_o <= rd_pend_r;
            if (rd_pend_r) begin
                mgmt_rdata_o <= rd_ext_r ? ext_rdata_i : rd_hold_r;
            end
        end
    end

    // static pair and reference selects
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rmii_ref_rx_clk_o   <= 1'b0;
            pair_polarity_inv_o <= 1'b0;
            pair_swap_o         <= 1'b0;
            port_mirror_o       <= 1'b0;
        end else begin
            rmii_ref_rx_clk_o   <= cr2_r[CR2_RMII_REF_BIT];
            pair_polarity_inv_o <= !lfp_r[LFP_POLARITY_BIT];
            pair_swap_o         <= lfp_r[LFP_PAIR_SWAP_BIT];
            port_mirror_o       <= lfp_r[LFP_PAIR_SWAP_BIT]
                                   && lfp_r[LFP_POLARITY_BIT];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            idle_sym_err_o <= 1'b0;
        end else begin
            idle_sym_err_o <= rx_sym_err_i && rx_idle_i
                              && cr2_r[CR2_IDLE_SYMERR_BIT];
        end
    end

    // odd-nibble tracking on the transmit nibble strobe
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            nib_odd_r <= 1'b0;
            stretch_r <= 1'b0;
            tx_en_o   <= 1'b0;
            tx_er_o   <= 1'b0;
        end else if (tx_nib_stb_i) begin
            nib_odd_r <= tx_en_i ? !nib_odd_r : 1'b0;
            stretch_r <= !tx_en_i && tx_en_o && !stretch_r && nib_odd_r
                         && !cr2_r[CR2_ODD_NIB_DIS_BIT];
            if (!tx_en_i && tx_en_o && !stretch_r && nib_odd_r
                && !cr2_r[CR2_ODD_NIB_DIS_BIT]) begin
                tx_en_o <= 1'b1;
                tx_er_o <= 1'b1;
            end else begin
                tx_en_o <= tx_en_i;
                tx_er_o <= tx_er_i && tx_en_i;
            end
        end
    end

    // fast link-down window timer
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || win_start) begin
            win_cnt_r <= 11'h000;
        end else begin
            win_cnt_r <= win_cnt_r + 11'h001;
        end
    end

    assign win_start = (win_cnt_r == 11'(FLD_WINDOW_CYC - 1));

    plc_win_count #(.THRESH(RX_ERR_THRESH)) u_rx_err_cnt (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .en_i        (lfp_r[LFP_RX_ERR_BIT]),
        .evt_i       (fault_evt_i.rx_err),
        .win_start_i (win_start),
        .hit_o       (rx_err_hit)
    );

    plc_win_count #(.THRESH(TERNARY_THRESH)) u_tern_cnt (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .en_i        (lfp_r[LFP_TERNARY_BIT]),
        .evt_i       (fault_evt_i.ternary_viol),
        .win_start_i (win_start),
        .hit_o       (tern_hit)
    );

    plc_win_count #(.THRESH(LOW_SNR_THRESH)) u_snr_cnt (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .en_i        (lfp_r[LFP_LOW_SNR_BIT]),
        .evt_i       (fault_evt_i.low_snr),
        .win_start_i (win_start),
        .hit_o       (snr_hit)
    );

    // drop follows the causes; a sustained loss keeps the link held down
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            link_drop_o <= 1'b0;
        end else begin
            link_drop_o <= (lfp_r[LFP_DESCR_LOSS_BIT] && fault_evt_i.descr_lock_lost)
                           || (lfp_r[LFP_ENERGY_BIT] && fault_evt_i.energy_lost)
                           || rx_err_hit || tern_hit || snr_hit;
        end
    end
endmodule

// ===== rtl/plc_pkg.sv
// constants and carriers for the link control and extended access block
// assumes a management frame engine on ref_clk_i presenting word accesses
// Summary of operation
// - second control bit 2, reset one, enables idle-state receive symbol error flagging
// - second control bit 1 clear: odd-nibble tx_en drop stretched one nibble strobe as error
// - second control bit 0 picks rmii receive reference: 1 rx clock, 0 crystal
// - third control bits 15:11 and 9:7 read zero, writes discarded
// - third control bit 10 drops link on descrambler lock loss
// - third control bit 6 low swaps legs of both wire pairs
// - third control bit 5 high swaps transmit and receive wire pairs
// - port mirroring active only when bits 5 and 6 both high
// - bit 3: 32 receive errors within 10 us drops link
// - bit 2: 20 ternary code violations within 10 us drops link
// - bit 1: 20 low snr crossings within 10 us drops link
// - bit 0: energy loss drops link, well inside 10 us
// - link drop is or of the five enabled criteria
// - extended registers reached only through control 0x0d and window 0x0e
// - function 00: window write loads the extended pointer
// - function 01: window access targets pointed register, pointer unchanged
// - function 10: window read or write then increments pointer
// - function 11: pointer increments after window writes only
// - indirect access needs device code all ones, otherwise ignored
package plc_pkg;
    localparam logic [4:0]  ADDR_RX_ERR_RMII_CTRL  = 5'h0a;
    localparam logic [4:0]  ADDR_LINK_FAULT_PAIR   = 5'h0b;
    localparam logic [4:0]  ADDR_INDIRECT_CTRL     = 5'h0d;
    localparam logic [4:0]  ADDR_INDIRECT_WINDOW   = 5'h0e;
    localparam logic [15:0] RST_RX_ERR_RMII_CTRL   = 16'h0004;
    localparam logic [15:0] RST_LINK_FAULT_PAIR    = 16'h0000;
    localparam logic [15:0] RST_INDIRECT_CTRL      = 16'h0000;
    localparam logic [15:0] RST_EXT_POINTER        = 16'h0000;
    localparam logic [15:0] LFP_WRITABLE_MASK      = 16'h047f;
    localparam logic [15:0] IAC_WRITABLE_MASK      = 16'hc01f;
    localparam int          CR2_IDLE_SYMERR_BIT    = 2;
    localparam int          CR2_ODD_NIB_DIS_BIT    = 1;
    localparam int          CR2_RMII_REF_BIT       = 0;
    localparam int          LFP_DESCR_LOSS_BIT     = 10;
    localparam int          LFP_POLARITY_BIT       = 6;
    localparam int          LFP_PAIR_SWAP_BIT      = 5;
    localparam int          LFP_RX_ERR_BIT         = 3;
    localparam int          LFP_TERNARY_BIT        = 2;
    localparam int          LFP_LOW_SNR_BIT        = 1;
    localparam int          LFP_ENERGY_BIT         = 0;
    localparam int          IAC_FUNC_HI            = 15;
    localparam int          IAC_FUNC_LO            = 14;
    localparam logic [4:0]  TARGET_DEVICE_CODE     = 5'h1f;
    localparam int          CLK_PERIOD_NS          = 8;
    localparam int          FLD_WINDOW_NS          = 10000;
    localparam int          FLD_WINDOW_CYC         = FLD_WINDOW_NS / CLK_PERIOD_NS;
    localparam int          RX_ERR_THRESH          = 32;
    localparam int          TERNARY_THRESH         = 20;
    localparam int          LOW_SNR_THRESH         = 20;

    typedef enum logic [1:0] {
        PLC_FN_ADDR,
        PLC_FN_DATA,
        PLC_FN_DATA_INC_RW,
        PLC_FN_DATA_INC_WR
    } plc_func_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } plc_mgmt_req_s;

    typedef struct packed {
        logic descr_lock_lost;
        logic rx_err;
        logic ternary_viol;
        logic low_snr;
        logic energy_lost;
    } plc_fault_evt_s;
endpackage

// ===== rtl/plc_win_count.sv
// counts fault events inside a fixed window and fires at the threshold
// assumes win_start_i pulses once per window on the same clock
`timescale 1ns/1ps
module plc_win_count
    import plc_pkg::*;
#(
    parameter int THRESH = 20
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic en_i,
    input  wire logic evt_i,
    input  wire logic win_start_i,
    output logic      hit_o
);
    logic [6:0] cnt_r;

    // fixed windows: a burst straddling a boundary may be split, cheaper than a sliding count
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || win_start_i || !en_i) begin
            cnt_r <= 7'h00;
        end else if (evt_i && cnt_r != 7'h7f) begin
            cnt_r <= cnt_r + 7'h01;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            hit_o <= 1'b0;
        end else begin
            hit_o <= en_i && !win_start_i && evt_i && (cnt_r == 7'(THRESH - 1));
        end
    end
endmodule

// ===== test/plc_ext_model.sv
// extended register file standing behind the indirect window
// assumes same-clock strobes; read data is combinational while ext_rd_i is high
`timescale 1ns/1ps
module plc_ext_model (
    input  wire logic        ref_clk_i,
    input  wire logic        ext_wr_i,
    input  wire logic        ext_rd_i,
    input  wire logic [15:0] ext_addr_i,
    input  wire logic [15:0] ext_wdata_i,
    output logic [15:0]      ext_rdata_o
);
    logic [15:0] mem [256];
    logic [15:0] junk_r = 16'h5a5a;
    // only low pointer bits decode; enough for the addresses the bench uses
    always_ff @(posedge ref_clk_i) begin
        junk_r <= ~junk_r + 16'h0001;
        if (ext_wr_i) begin
            mem[ext_addr_i[7:0]] <= ext_wdata_i;
        end
    end
    // not selected: a changing pattern so stale data cannot pass
    assign ext_rdata_o = ext_rd_i ? mem[ext_addr_i[7:0]] : junk_r;
endmodule

// ===== test/plc_link_ctrl_assertions.sv
// port checker for the link control block
// assumes one clock; register shadows are rebuilt from observed writes
`timescale 1ns/1ps
module plc_link_ctrl_assertions
    import plc_pkg::*;
(
    input wire logic           ref_clk_i,
    input wire logic           rst_i,
    input wire plc_mgmt_req_s  mgmt_req_i,
    input wire logic [15:0]    mgmt_rdata_o,
    input wire logic           mgmt_rvalid_o,
    input wire logic           ext_wr_o,
    input wire logic           ext_rd_o,
    input wire logic [15:0]    ext_wdata_o,
    input wire logic           rx_sym_err_i,
    input wire logic           rx_idle_i,
    input wire logic           idle_sym_err_o,
    input wire logic           tx_nib_stb_i,
    input wire logic           tx_en_i,
    input wire logic           tx_en_o,
    input wire logic           tx_er_o,
    input wire logic           rmii_ref_rx_clk_o,
    input wire logic           pair_polarity_inv_o,
    input wire logic           pair_swap_o,
    input wire logic           port_mirror_o,
    input wire plc_fault_evt_s fault_evt_i,
    input wire logic           link_drop_o
);
    logic [15:0] cr2_r, lfp_r, iac_r;
    logic        par_r, en_any, win_ok;
    assign en_any = lfp_r[10] | (|lfp_r[3:0]);
    assign win_ok = iac_r[4:0] == TARGET_DEVICE_CODE;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cr2_r <= RST_RX_ERR_RMII_CTRL;
            lfp_r <= '0;
            iac_r <= '0;
        end else if (mgmt_req_i.wr) begin
            if (mgmt_req_i.addr == ADDR_RX_ERR_RMII_CTRL) cr2_r <= mgmt_req_i.wdata;
            if (mgmt_req_i.addr == ADDR_LINK_FAULT_PAIR) lfp_r <= mgmt_req_i.wdata & 16'h047f;
            if (mgmt_req_i.addr == ADDR_INDIRECT_CTRL) iac_r <= mgmt_req_i.wdata & 16'hc01f;
        end
    end
    // nibble parity of the running frame
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) par_r <= 1'b0;
        else if (tx_nib_stb_i) par_r <= tx_en_i & ~par_r;
    end
    rd_answer_a: assert property (mgmt_req_i.rd && !mgmt_req_i.wr |-> ##2 mgmt_rvalid_o)
        else $error("read not answered after two cycles");
    lfp_mask_a: assert property (mgmt_req_i.rd && !mgmt_req_i.wr
        && mgmt_req_i.addr == ADDR_LINK_FAULT_PAIR |-> ##2 mgmt_rdata_o == $past(lfp_r, 2))
        else $error("third control read value wrong");
    rmii_ref_a: assert property (!$past(rst_i) && $stable(cr2_r) |-> rmii_ref_rx_clk_o == cr2_r[0])
        else $error("receive reference select wrong");
    polarity_a: assert property (!$past(rst_i) && $stable(lfp_r) |-> pair_polarity_inv_o == !lfp_r[6])
        else $error("polarity output wrong");
    pair_swap_a: assert property (!$past(rst_i) && $stable(lfp_r) |-> pair_swap_o == lfp_r[5])
        else $error("pair swap output wrong");
    port_mirror_a: assert property (!$past(rst_i) && $stable(lfp_r)
        |-> port_mirror_o == (lfp_r[5] && lfp_r[6]))
        else $error("mirror output wrong");
    idle_err_a: assert property (!$past(rst_i)
        |=> idle_sym_err_o == $past(rx_sym_err_i && rx_idle_i && cr2_r[2]))
        else $error("idle symbol error flag wrong");
    descr_drop_a: assert property (lfp_r[10] && fault_evt_i.descr_lock_lost |=> link_drop_o)
        else $error("no drop on descrambler loss");
    energy_drop_a: assert property (lfp_r[0] && fault_evt_i.energy_lost |=> link_drop_o)
        else $error("no drop on energy loss");
    drop_cause_a: assert property (link_drop_o |-> $past(en_any) || $past(en_any, 2))
        else $error("link drop with no enabled cause");
    dev_code_a: assert property ((mgmt_req_i.wr || mgmt_req_i.rd) && !win_ok
        && mgmt_req_i.addr == ADDR_INDIRECT_WINDOW |=> !ext_wr_o && !ext_rd_o)
        else $error("window access with wrong device code");
    ext_write_a: assert property (mgmt_req_i.wr && win_ok && iac_r[15:14] != 2'b00
        && mgmt_req_i.addr == ADDR_INDIRECT_WINDOW
        |=> ext_wr_o && ext_wdata_o == $past(mgmt_req_i.wdata))
        else $error("window write not passed on");
    odd_nibble_a: assert property (tx_nib_stb_i && !tx_en_i && par_r && !cr2_r[1]
        |=> tx_en_o && tx_er_o)
        else $error("odd nibble end not stretched");
endmodule
bind plc_link_ctrl plc_link_ctrl_assertions plc_link_ctrl_assertions_i (.*);

// ===== test/plc_link_ctrl_tb.sv
// self-checking bench for the link control block
// assumes the extended register model answers window reads in the same cycle
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module plc_link_ctrl_tb;
    import plc_pkg::*;
    logic           ref_clk_i = 1'b0;
    logic           rst_i = 1'b1;
    plc_mgmt_req_s  mgmt_req_i = '0;
    plc_fault_evt_s fault_evt_i = '0;
    logic [15:0]    mgmt_rdata_o, ext_addr_o, ext_wdata_o, ext_rdata_i, exp_v, a, b, c, v;
    logic           mgmt_rvalid_o, ext_wr_o, ext_rd_o, idle_sym_err_o, tx_en_o, tx_er_o;
    logic           rmii_ref_rx_clk_o, pair_polarity_inv_o, pair_swap_o, port_mirror_o;
    logic           link_drop_o;
    logic           rx_sym_err_i = 1'b0, rx_idle_i = 1'b0;
    logic           tx_nib_stb_i = 1'b0, tx_en_i = 1'b0, tx_er_i = 1'b0;
    logic [15:0]    exp_q [$];
    int             n_fail, comparisons, n_drop;
    plc_link_ctrl plc_link_ctrl_i (.*);
    plc_ext_model plc_ext_model_i (
        .ref_clk_i   (ref_clk_i),
        .ext_wr_i    (ext_wr_o),
        .ext_rd_i    (ext_rd_o),
        .ext_addr_i  (ext_addr_o),
        .ext_wdata_i (ext_wdata_o),
        .ext_rdata_o (ext_rdata_i)
    );
    initial forever #4 ref_clk_i = ~ref_clk_i;
    // one access; a read notes d as the expected answer
    task automatic acc(input logic w, input logic [4:0] ad, input logic [15:0] d);
        if (!w) exp_q.push_back(d);
        @(posedge ref_clk_i);
        #1 mgmt_req_i = '{w, !w, ad, w ? d : 16'h0000};
        @(posedge ref_clk_i);
        #1 mgmt_req_i = '0;
    endtask
    task automatic frame(input int n, input logic dis);
        acc(1, ADDR_RX_ERR_RMII_CTRL, {13'h0000, 1'b1, dis, 1'b0});
        for (int i = 0; i <= n; i++) begin
            @(posedge ref_clk_i);
            #1 tx_nib_stb_i = 1'b1;
            tx_en_i = i < n;
            @(posedge ref_clk_i);
            #1 tx_nib_stb_i = 1'b0;
        end
        `CHK("tx_er_o", n[0] & !dis, tx_er_o)
        `CHK("tx_en_o", n[0] & !dis, tx_en_o)
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        if (link_drop_o === 1'b1) n_drop++;
        if (mgmt_rvalid_o === 1'b1) begin
            exp_v = exp_q.pop_front();
            `CHK("mgmt_rdata_o", exp_v, mgmt_rdata_o)
        end
    end
    // idle and symbol error levels wander throughout the run
    always @(posedge ref_clk_i) begin
        #1 {rx_sym_err_i, rx_idle_i} = 2'($urandom);
    end
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
    initial begin
        void'($urandom(32'h69d17525));
        repeat (3) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        acc(0, ADDR_RX_ERR_RMII_CTRL, 16'h0004);
        acc(0, ADDR_LINK_FAULT_PAIR, 16'h0000);
        acc(0, ADDR_INDIRECT_WINDOW, 16'h0000);
        acc(0, 5'h03, 16'h0000);
        acc(1, ADDR_INDIRECT_CTRL, 16'h001f);
        acc(0, ADDR_INDIRECT_WINDOW, 16'h0000);
        acc(1, ADDR_INDIRECT_CTRL, 16'hffff);
        acc(0, ADDR_INDIRECT_CTRL, 16'hc01f);
        acc(1, ADDR_LINK_FAULT_PAIR, 16'hffff);
        acc(0, ADDR_LINK_FAULT_PAIR, 16'h047f);
        repeat (4) begin
            v = 16'($urandom);
            acc(1, ADDR_RX_ERR_RMII_CTRL, v);
            acc(0, ADDR_RX_ERR_RMII_CTRL, v);
            `CHK("rmii_ref_rx_clk_o", v[0], rmii_ref_rx_clk_o)
            acc(1, ADDR_LINK_FAULT_PAIR, v);
            acc(0, ADDR_LINK_FAULT_PAIR, v & 16'h047f);
            `CHK("pair_polarity_inv_o", !v[6], pair_polarity_inv_o)
            `CHK("pair_swap_o", v[5], pair_swap_o)
            `CHK("port_mirror_o", v[5] & v[6], port_mirror_o)
        end
        acc(1, ADDR_LINK_FAULT_PAIR, 16'h0060);
        @(posedge ref_clk_i);
        #1;
        `CHK("port_mirror_o", 1'b1, port_mirror_o)
        `CHK("pair_polarity_inv_o", 1'b0, pair_polarity_inv_o)
        a = 16'($urandom);
        b = 16'($urandom);
        c = 16'($urandom);
        acc(1, ADDR_INDIRECT_CTRL, 16'h001f);
        acc(1, ADDR_INDIRECT_WINDOW, 16'hfffe);
        acc(0, ADDR_INDIRECT_WINDOW, 16'hfffe);
        acc(1, ADDR_INDIRECT_CTRL, 16'h801f);
        acc(1, ADDR_INDIRECT_WINDOW, a);
        acc(1, ADDR_INDIRECT_WINDOW, b);
        acc(1, ADDR_INDIRECT_CTRL, 16'h001f);
        acc(0, ADDR_INDIRECT_WINDOW, 16'h0000);
        acc(1, ADDR_INDIRECT_WINDOW, 16'hfffe);
        acc(1, ADDR_INDIRECT_CTRL, 16'h401f);
        repeat (2) acc(0, ADDR_INDIRECT_WINDOW, a);
        acc(1, ADDR_INDIRECT_CTRL, 16'hc01f);
        acc(0, ADDR_INDIRECT_WINDOW, a);
        acc(1, ADDR_INDIRECT_WINDOW, c);
        acc(0, ADDR_INDIRECT_WINDOW, b);
        acc(1, ADDR_INDIRECT_CTRL, 16'h801f);
        acc(0, ADDR_INDIRECT_WINDOW, b);
        acc(1, ADDR_INDIRECT_CTRL, 16'h001e);
        acc(0, ADDR_INDIRECT_WINDOW, 16'h0000);
        acc(1, ADDR_INDIRECT_WINDOW, c);
        acc(1, ADDR_INDIRECT_CTRL, 16'h001f);
        acc(0, ADDR_INDIRECT_WINDOW, 16'h0000);
        // 64 spaced events straddle at most one window edge, so one window sees 32;
        // one event short of the threshold can never reach it in any window
        for (int i = 0; i <= 7; i++) begin
            v = i == 4 ? 16'h0400 : i == 5 ? 16'h0000 : i == 6 ? 16'h0008
                : i == 7 ? 16'h0004 : 16'h0001 << i;
            acc(1, ADDR_LINK_FAULT_PAIR, v);
            n_drop = 0;
            repeat (i == 6 ? RX_ERR_THRESH - 1 : i == 7 ? TERNARY_THRESH - 1 : 64) begin
                @(posedge ref_clk_i);
                #1 fault_evt_i = plc_fault_evt_s'(i == 5 ? 5'h1f
                                 : i >= 6 ? 5'h08 >> (i - 6) : 5'h01 << i);
                @(posedge ref_clk_i);
                #1 fault_evt_i = '0;
            end
            repeat (3) @(posedge ref_clk_i);
            `CHK("link_drop_o", i < 5, n_drop != 0)
        end
        frame(3, 1'b0);
        frame(4, 1'b0);
        frame(3, 1'b1);
        repeat (4) @(posedge ref_clk_i);
        `CHK("pending reads", 0, exp_q.size())
        summarize();
    end
endmodule
